// ### core/irq_bank_map.svh
/*
  Constants of the interrupt state register bank: sizes, register window
  offsets and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH

// Group and interrupt counts
`define NUM_GROUPS      16
`define GROUP_W         32
`define NUM_IRQ         512
`define IRQ_ID_W        9
`define PRIO_W          8
`define GROUP_SEL_W     4
`define BIT_SEL_W       5

// Byte offsets of each register window from the bank base
`define ADDR_W          10
`define OFF_SET_ENABLE  10'h000
`define OFF_CLR_ENABLE  10'h080
`define OFF_SET_PENDING 10'h100
`define OFF_CLR_PENDING 10'h180
`define OFF_ACTIVE      10'h200
`define OFF_TARGET      10'h280

// Zero reset value and all-ones visibility mask of a register word
`define RST_WORD        32'h0000_0000
`define ONES_WORD       32'hFFFF_FFFF

// Option: security partitioning built in
`define SECURITY_EXT    1'b1

`endif

// ### core/irq_bank_pkg.sv
/*
  Types of the interrupt state register bank.
  Assumes irq_bank_map.svh on the include path.
*/
`include "irq_bank_map.svh"

package irq_bank_pkg;

  typedef logic [`GROUP_W-1:0]           word_type;    // One register word
  typedef word_type [`NUM_GROUPS-1:0]    bank_type;    // Sixteen words
  typedef logic [`NUM_IRQ-1:0]           irq_vec_type; // One bit per line
  typedef logic [`PRIO_W-1:0]            prio_type;    // Priority level
  typedef prio_type [`NUM_IRQ-1:0]       prio_vec_type;
  typedef logic [`IRQ_ID_W-1:0]          irq_id_type;  // Interrupt number

  // Core handshake event: one-cycle strobe with interrupt number
  typedef struct packed {
    logic       strobe;
    irq_id_type id;
  } core_event_type;

  // Best candidate offered to the core
  typedef struct packed {
    logic       valid;
    irq_id_type id;
    prio_type   level;
  } take_req_type;

  // Bus phase, Gray coded
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_type;

  // Register window selected by address bits [9:7]
  typedef enum logic [2:0] {
    SEL_SET_EN  = 3'h0,
    SEL_CLR_EN  = 3'h1,
    SEL_SET_PND = 3'h2,
    SEL_CLR_PND = 3'h3,
    SEL_ACTIVE  = 3'h4,
    SEL_TARGET  = 3'h5
  } reg_sel_type;

  // Whole state of the bank
  typedef struct packed {
    bank_type      enable;
    bank_type      pending;
    bank_type      active;
    bank_type      target;
    irq_vec_type   line_meta;
    irq_vec_type   line_sync;
    irq_vec_type   line_prev;
    bus_state_type bus;
    logic          waitrequest;
    word_type      readdata;
  } bank_state_type;

  // Whole state of the arbiter
  typedef struct packed {
    take_req_type take;
  } arb_state_type;

endpackage : irq_bank_pkg

// ### core/irq_take_arbiter.sv
/*
  Picks the most urgent eligible interrupt and registers it for the core.
  Assumes eligibility and levels come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_map.svh"

module irq_take_arbiter
(
  input  wire logic                        clk_i,     // Clock
  input  wire logic                        resetn_i,  // Async reset
  input  wire irq_bank_pkg::irq_vec_type   eligible_i,
  input  wire irq_bank_pkg::prio_vec_type  levels_i,
  output var  irq_bank_pkg::take_req_type  take_o
);

  irq_bank_pkg::arb_state_type state;      // Registered state
  irq_bank_pkg::arb_state_type next_state; // Next state

  ////////////////////////////////////////////////////////////////////////
  // Lowest level wins, ties go to lowest number
  always_comb
  begin
    next_state = state;
    next_state.take = '0;
    for (int i = 0; i < `NUM_IRQ; i++)
    begin
      if (eligible_i[i] && (!next_state.take.valid ||
          levels_i[i] < next_state.take.level))
      begin
        next_state.take.valid = 1'b1;
        next_state.take.id    = irq_bank_pkg::irq_id_type'(i);
        next_state.take.level = levels_i[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign take_o = state.take;

endmodule : irq_take_arbiter
`default_nettype wire

// ### core/irq_enable_pending_active_bank.sv
/*
  Per-interrupt enable, pending, active and target bank with an
  Avalon-MM slave, line sampling and the core activation hooks.
  Assumes a 50 MHz clk_i, async active-low reset, sideband security and
  privilege qualifiers in step with the bus request, and a core that
  reports handler entry and return as one-cycle strobes.
*/
// Operation
// - Set-enable bit m governs interrupt 32n+m
// - Pending and enabled interrupts compete by priority
// - Disabled lines still pend but never activate
// - Clear-enable writes one disable, reads enable
// - Set-pending writes one pend, reads pending
// - Pending interrupt stays same on set-pending
// - Set-pending on disabled interrupt leaves it disabled
// - Clear-pending writes one unpend, reads pending
// - Clear-pending leaves active state alone
// - Active bit reads one while interrupt active
// - Target bit: one Non-secure, zero Secure
// - Sixteen 32-bit words per register type
// - Target words reachable only from Secure state
// - Without partitioning, target reads zero, ignores writes
// - Non-secure sees Secure-targeted bits as zero
// - One shared copy for both security states
// - Active view uses the 32n+m mapping
// - Handler entry clears pending, sets active
// - Level line still high on return repends
// - Lower level number is more urgent

`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_map.svh"

module irq_enable_pending_active_bank
(
  input  wire logic                        clk_i,            // Clock
  input  wire logic                        resetn_i,         // Async reset
  input  wire logic [`ADDR_W-1:0]          avs_address_i,    // Byte address
  input  wire logic                        avs_read_i,       // Read request
  input  wire logic                        avs_write_i,      // Write request
  input  wire logic [31:0]                 avs_writedata_i,  // Write data
  input  wire logic [3:0]                  avs_byteenable_i, // Byte lanes
  output var  logic [31:0]                 avs_readdata_o,   // Read data
  output var  logic                        avs_waitrequest_o,// Stall
  input  wire logic                        access_secure_i,  // Secure access
  input  wire logic                        access_priv_i,    // Privileged
  input  wire irq_bank_pkg::irq_vec_type   irq_lines_i,      // Request pins
  input  wire irq_bank_pkg::irq_vec_type   level_sense_i,    // 1 = level
  input  wire irq_bank_pkg::prio_vec_type  priority_levels_i,// Levels
  input  wire irq_bank_pkg::core_event_type activate_i,      // Handler entry
  input  wire irq_bank_pkg::core_event_type return_i,        // Handler exit
  output var  irq_bank_pkg::take_req_type  take_o            // Candidate
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  irq_bank_pkg::bank_state_type state;      // Registered state
  irq_bank_pkg::bank_state_type next_state; // Next state

  // Address decode
  irq_bank_pkg::reg_sel_type  sel;          // Decoded window
  logic [`GROUP_SEL_W-1:0]    grp;          // Decoded group n
  logic                       mapped;       // Address hits a word
  logic                       ns_view;      // Non-secure access view

  // Masks
  logic [31:0]                byte_mask;    // Lanes as bit mask
  logic [31:0]                vis_mask;     // Bits this access may see
  logic [31:0]                wr_mask;      // Bits this write may touch
  logic [31:0]                rd_word;      // Word returned on read

  // Bus and arbiter
  logic                       bus_req;      // Read or write pending
  logic                       do_write;     // Write commits this cycle
  irq_bank_pkg::irq_vec_type  eligible;     // Offered to arbiter

  ////////////////////////////////////////////////////////////////////////
  // Address decode: bits [9:7] window, [5:2] group, bit 6 must be zero

  always_comb
  begin
    // Window and group
    sel    = irq_bank_pkg::reg_sel_type'(avs_address_i[9:7]);
    grp    = avs_address_i[5:2];

    // Six windows of sixteen words each
    mapped = (avs_address_i[9:7] <= 3'h5) && !avs_address_i[6];
  end

  ////////////////////////////////////////////////////////////////////////
  // Access qualification

  always_comb
  begin
    // Non-secure view only exists with partitioning built in
    ns_view = `SECURITY_EXT && !access_secure_i;

    // Byte enables widened to a bit mask
    for (int k = 0; k < 4; k++)
    begin
      byte_mask[8*k +: 8] = {8{avs_byteenable_i[k]}};
    end

    // Secure-targeted bits hidden from Non-secure state
    if (ns_view)
      vis_mask = state.target[grp];
    else
      vis_mask = `ONES_WORD;

    // Unprivileged access sees nothing
    if (!access_priv_i)
      vis_mask = `RST_WORD;
    // Visible lanes only
    wr_mask = avs_writedata_i & byte_mask & vis_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read word selection

  always_comb
  begin
    // Zero unless selected
    rd_word = `RST_WORD;
    if (mapped)
    begin
      case (sel)
        // Both enable views show the enable state
        irq_bank_pkg::SEL_SET_EN:
          rd_word = state.enable[grp] & vis_mask;
        irq_bank_pkg::SEL_CLR_EN:
          rd_word = state.enable[grp] & vis_mask;
        // Both pending views show the pending state
        irq_bank_pkg::SEL_SET_PND:
          rd_word = state.pending[grp] & vis_mask;
        irq_bank_pkg::SEL_CLR_PND:
          rd_word = state.pending[grp] & vis_mask;
        // Active state per interrupt
        irq_bank_pkg::SEL_ACTIVE:
          rd_word = state.active[grp] & vis_mask;
        // Target word: Secure only, absent without partitioning
        irq_bank_pkg::SEL_TARGET:
        begin
          if (`SECURITY_EXT && !ns_view && access_priv_i)
            rd_word = state.target[grp];
          else
            rd_word = `RST_WORD;
        end
        // Holes read as zero
        default:
          rd_word = `RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus request and commit point

  always_comb
  begin
    bus_req  = avs_read_i || avs_write_i;
    // Commit on the taking edge
    do_write = avs_write_i && (state.bus == irq_bank_pkg::BUS_IDLE)
               && mapped;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    // Loop scratch
    logic act_hit;   // Handler entry for this interrupt
    logic ret_hit;   // Handler return for this interrupt
    logic hw_set;    // Line event sets pending
    logic sw_set;    // Software set-pending write
    logic sw_clr;    // Software clear-pending write
    logic in_grp;    // Interrupt lies in addressed group

    // Cleared up front
    act_hit = 1'b0;
    ret_hit = 1'b0;
    hw_set  = 1'b0;
    sw_set  = 1'b0;
    sw_clr  = 1'b0;
    in_grp  = 1'b0;

    // Kept unless changed below
    next_state = state;

    // Two-flop synchroniser plus edge history on the request pins
    next_state.line_meta = irq_lines_i;
    next_state.line_sync = state.line_meta;
    next_state.line_prev = state.line_sync;

    // Bus handshake: one idle cycle, then one cycle with waitrequest low
    case (state.bus)
      irq_bank_pkg::BUS_IDLE:
      begin
        // Take any request
        if (bus_req)
        begin
          next_state.bus         = irq_bank_pkg::BUS_ACK;
          next_state.waitrequest = 1'b0;

          // Read data captured with the answer, zero on writes
          next_state.readdata    = avs_read_i ? rd_word : `RST_WORD;
        end
      end
      irq_bank_pkg::BUS_ACK:
      begin
        // Master releases at this edge
        next_state.bus         = irq_bank_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
      end
      // Unused codes fall back
      default:
      begin
        next_state.bus         = irq_bank_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
      end
    endcase

    // Software writes: one shared copy, no banking by security state
    if (do_write)
    begin
      case (sel)
        // Ones enable, zeros ignored
        irq_bank_pkg::SEL_SET_EN:
          next_state.enable[grp] = state.enable[grp] | wr_mask;
        // Ones disable, zeros ignored
        irq_bank_pkg::SEL_CLR_EN:
          next_state.enable[grp] = state.enable[grp] & ~wr_mask;

        // Target word written only from Secure state when built in
        irq_bank_pkg::SEL_TARGET:
        begin
          if (`SECURITY_EXT && !ns_view)
            next_state.target[grp] =
              (state.target[grp] & ~(byte_mask & vis_mask)) |
              wr_mask;
        end
        // Pending windows handled per bit below, active is read-only
        default:
        begin
        end
      endcase
    end

    // Per-interrupt pending and active update
    for (int i = 0; i < `NUM_IRQ; i++)
    begin
      // Strobes aimed here
      act_hit = activate_i.strobe &&
                (activate_i.id == irq_bank_pkg::irq_id_type'(i));
      ret_hit = return_i.strobe &&
                (return_i.id == irq_bank_pkg::irq_id_type'(i));
      // Software window hits
      in_grp  = (grp == `GROUP_SEL_W'(i / `GROUP_W));
      sw_set  = do_write && in_grp && (sel == irq_bank_pkg::SEL_SET_PND) &&
                wr_mask[i % `GROUP_W];
      sw_clr  = do_write && in_grp && (sel == irq_bank_pkg::SEL_CLR_PND) &&
                wr_mask[i % `GROUP_W];

      // Level: asserted and not active; pulse: rising edge of the line
      if (level_sense_i[i])
        hw_set = state.line_sync[i] &&
                 !(state.active[i / `GROUP_W][i % `GROUP_W] || act_hit);
      else
        hw_set = state.line_sync[i] && !state.line_prev[i];

      // Level line still high at return pends again
      if (ret_hit && level_sense_i[i] && state.line_sync[i])
        hw_set = 1'b1;

      // Clears first, sets after so an event in the same cycle wins
      if (sw_clr || act_hit)
        next_state.pending[i / `GROUP_W][i % `GROUP_W] = 1'b0;
      // Enable state plays no part here; a pending bit just stays set
      if (sw_set || hw_set)
        next_state.pending[i / `GROUP_W][i % `GROUP_W] = 1'b1;

      // Active follows the core only, never the clear-pending window
      if (ret_hit)
        next_state.active[i / `GROUP_W][i % `GROUP_W] = 1'b0;
      if (act_hit)
        next_state.active[i / `GROUP_W][i % `GROUP_W] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register: everything cleared, waitrequest held high

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Clear all state
      state             <= '0;
      state.bus         <= irq_bank_pkg::BUS_IDLE;
      state.waitrequest <= 1'b1;
    end
    else
    begin
      // Take next state
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Eligibility: enabled, pending and not already active

  always_comb
  begin
    for (int i = 0; i < `NUM_IRQ; i++)
    begin
      // Bit m of word n
      eligible[i] = state.pending[i / `GROUP_W][i % `GROUP_W] &&
                    state.enable[i / `GROUP_W][i % `GROUP_W] &&
                    !state.active[i / `GROUP_W][i % `GROUP_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority selection of the candidate

  // Output is registered
  irq_take_arbiter u_arbiter
  (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .eligible_i (eligible),
    .levels_i   (priority_levels_i),
    .take_o     (take_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus outputs straight from the state register

  assign avs_readdata_o    = state.readdata;
  assign avs_waitrequest_o = state.waitrequest;

endmodule : irq_enable_pending_active_bank
`default_nettype wire

// ### sim/irq_bank_chk.sv
/*
  Checker of the bank: bus handshake, refused reads and take output.
  Assumes binding to irq_enable_pending_active_bank, priority levels
  held steady by the bench after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_bank_chk
(
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic [9:0]                   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  input  wire logic [31:0]                  avs_readdata_o,
  input  wire logic                         avs_waitrequest_o,
  input  wire logic                         access_secure_i,
  input  wire logic                         access_priv_i,
  input  wire irq_bank_pkg::prio_vec_type   priority_levels_i,
  input  wire irq_bank_pkg::core_event_type activate_i,
  input  wire irq_bank_pkg::core_event_type return_i,
  input  wire irq_bank_pkg::take_req_type   take_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////////////
  // Request taken by an idle slave
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  // Read that must answer zero: unprivileged, unmapped, hidden target
  sequence s_zero_read;
    avs_read_i && avs_waitrequest_o && (!access_priv_i
      || avs_address_i[9:7] > 3'h5 || avs_address_i[6]
      || (!access_secure_i && avs_address_i[9:7] == 3'h5));
  endsequence
  // Whole-word clear-enable from secure privileged software
  sequence s_kill_word;
    avs_write_i && avs_waitrequest_o && access_priv_i && access_secure_i
      && avs_address_i[9:6] == 4'h2 && avs_byteenable_i == 4'hF
      && avs_writedata_i == 32'hFFFF_FFFF;
  endsequence
  //////////////////////////////////////////////////////////////////////
  chk_answer_next: assert property (
    s_taken |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("answer not one cycle after request");
  chk_idle_stall: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("answer without request");
  chk_zero_read: assert property (
    s_zero_read |=> avs_readdata_o == 32'h0)
    else $error("refused read returned data");
  chk_write_quiet: assert property (
    avs_write_i && avs_waitrequest_o |=> avs_readdata_o == 32'h0)
    else $error("write answer carried data");
  chk_reset_state: assert property (
    $rose(resetn_i) |-> avs_waitrequest_o && !take_o.valid)
    else $error("bank not idle after reset");
  chk_take_level: assert property (
    take_o.valid |-> take_o.level == priority_levels_i[take_o.id])
    else $error("take level does not match its interrupt");
  chk_kill_take: assert property (
    s_kill_word |=> ##1 !(take_o.valid
      && take_o.id[8:5] == $past(avs_address_i[5:2], 2)))
    else $error("disabled interrupt still offered");
  chk_entry_drop: assert property (
    activate_i.strobe ##1 !return_i.strobe
      |=> !(take_o.valid && take_o.id == $past(activate_i.id, 2)))
    else $error("active interrupt still offered");
endmodule : irq_bank_chk

bind irq_enable_pending_active_bank irq_bank_chk i_irq_bank_chk
(
  .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .access_secure_i(access_secure_i), .access_priv_i(access_priv_i),
  .priority_levels_i(priority_levels_i), .activate_i(activate_i),
  .return_i(return_i), .take_o(take_o)
);
`default_nettype wire

// ### sim/irq_core_model.sv
/*
  Core model: takes the offered interrupt when allowed, stays in the
  handler a given number of cycles, then returns. No nesting.
  Assumes take_i registered on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_core_model
(
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         accept_i,   // May take
  input  wire logic [7:0]                   stay_i,     // Handler cycles
  input  wire irq_bank_pkg::take_req_type   take_i,
  output var  irq_bank_pkg::core_event_type activate_o,
  output var  irq_bank_pkg::core_event_type return_o
);
  logic       busy; // In a handler
  logic [7:0] left; // Cycles still to stay
  // Entry, countdown and return strobes
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy       <= 1'b0;
      left       <= 8'h0;
      activate_o <= '0;
      return_o   <= '0;
    end
    else
    begin
      activate_o.strobe <= 1'b0;
      return_o.strobe   <= 1'b0;
      if (!busy && accept_i && take_i.valid)
      begin
        busy        <= 1'b1;
        left        <= stay_i;
        activate_o  <= {1'b1, take_i.id};
        return_o.id <= take_i.id;
      end
      else if (busy && left != 8'h0)
        left <= left - 8'h1;
      else if (busy)
      begin
        busy            <= 1'b0;
        return_o.strobe <= 1'b1;
      end
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ### sim/test_irq_enable_pending_active_bank.sv
/*
  Self-checking bench of the interrupt state bank.
  Assumes the package, the core model and the checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_map.svh"
module test_irq_enable_pending_active_bank;
  typedef irq_bank_pkg::word_type wrd_type;
  localparam logic [9:0] OFFS [6] = '{`OFF_SET_ENABLE, `OFF_CLR_ENABLE,
    `OFF_SET_PENDING, `OFF_CLR_PENDING, `OFF_ACTIVE, `OFF_TARGET};
  logic clk_i = 1'b0, resetn_i = 1'b0, rd = 1'b0, wr = 1'b0, waitreq;
  logic sec = 1'b1, priv = 1'b1, accept = 1'b0;
  logic [9:0] addr = 10'h0;
  logic [3:0] be = 4'hF, b;
  logic [7:0] stay = 8'h3C;
  wrd_type wdata = '0, rdata, d, q;
  wrd_type en [16] = '{default: '0};
  wrd_type pd [16] = '{default: '0};
  wrd_type tg [16] = '{default: '0};
  irq_bank_pkg::irq_vec_type    lines = '0, lsense = '0;
  irq_bank_pkg::prio_vec_type   levels;
  irq_bank_pkg::core_event_type act, ret;
  irq_bank_pkg::take_req_type   take;
  int fail_count = 0, checks = 0, cyc = 0, seed = 32'h2EDD, i, g, k;
  //////////////////////////////////////////////////////////////////////
  irq_enable_pending_active_bank i_irq_enable_pending_active_bank (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .access_secure_i(sec),
    .access_priv_i(priv), .irq_lines_i(lines), .level_sense_i(lsense),
    .priority_levels_i(levels), .activate_i(act), .return_i(ret),
    .take_o(take));
  irq_core_model i_irq_core_model (.clk_i(clk_i), .resetn_i(resetn_i),
    .accept_i(accept), .stay_i(stay), .take_i(take), .activate_o(act),
    .return_o(ret));
  //////////////////////////////////////////////////////////////////////
  initial forever #10 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  function automatic logic [9:0] a_of(input int w, input int n);
    return OFFS[w] + 10'(n * 4);
  endfunction : a_of
  function automatic wrd_type lanes(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction : lanes
  // Expected word of window w, group n; nothing active here
  function automatic wrd_type exp_of(input int w, input int n);
    return w < 2 ? en[n] : w < 4 ? pd[n] : w == 5 ? tg[n] : 32'h0;
  endfunction : exp_of
  // One bus access, entered just after a rising edge
  task automatic bus(input logic w, input logic [9:0] a, input wrd_type v,
                     input logic [3:0] m, output wrd_type r);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= v;
    be    <= m;
    @(posedge clk_i);
    while (waitreq !== 1'b0)
      @(posedge clk_i);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic cmp_word(input wrd_type got, input wrd_type exp);
    checks++;
    if (got !== exp)
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask : cmp_word
  task automatic cmp_id(input irq_bank_pkg::irq_id_type got, input int e);
    checks++;
    if (got !== 9'(e))
      $display("MISMATCH %0t id %0d expected %0d", $time, got, e);
    if (got !== 9'(e))
      fail_count++;
  endtask : cmp_id
  task automatic rdc(input logic [9:0] a, input wrd_type exp);
    wrd_type r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    cmp_word(r, exp);
  endtask : rdc
  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 512; i++)
      levels[i] = 8'($random(seed));
    levels[70]  = 8'h02;
    levels[200] = 8'h01;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (g = 0; g < 16; g++)
      for (k = 0; k < 6; k++)
        rdc(a_of(k, g), 32'h0);
    // Random writes to every window, then read all views back
    for (i = 0; i < 60; i++)
    begin
      g = $unsigned($random(seed)) % 16;
      k = $unsigned($random(seed)) % 6;
      d = $random(seed);
      b = 4'($random(seed));
      bus(1'b1, a_of(k, g), d, b, q);
      case (k)
        0: en[g] |= d & lanes(b);
        1: en[g] &= ~(d & lanes(b));
        2: pd[g] |= d & lanes(b);
        3: pd[g] &= ~(d & lanes(b));
        5: tg[g] = (tg[g] & ~lanes(b)) | (d & lanes(b));
        default: ; // Active view ignores writes
      endcase
      for (k = 0; k < 6; k++)
        rdc(a_of(k, g), exp_of(k, g));
    end
    // Whole-word clears of every group
    for (g = 0; g < 16; g++)
    begin
      bus(1'b1, a_of(1, g), '1, 4'hF, q);
      bus(1'b1, a_of(3, g), '1, 4'hF, q);
      en[g] = '0;
      pd[g] = '0;
    end
    // Non-secure access sees only its own half of group 3
    bus(1'b1, a_of(5, 3), 32'h0000_FFFF, 4'hF, q);
    sec <= 1'b0;
    bus(1'b1, a_of(0, 3), '1, 4'hF, q);
    bus(1'b1, a_of(2, 3), '1, 4'hF, q);
    bus(1'b1, a_of(5, 3), '1, 4'hF, q);
    rdc(a_of(0, 3), 32'h0000_FFFF);
    rdc(a_of(5, 3), 32'h0);
    sec <= 1'b1;
    rdc(a_of(2, 3), 32'h0000_FFFF);
    rdc(a_of(5, 3), 32'h0000_FFFF);
    // Unprivileged access and unmapped places
    priv <= 1'b0;
    bus(1'b1, a_of(3, 3), '1, 4'hF, q);
    rdc(a_of(2, 3), 32'h0);
    priv <= 1'b1;
    rdc(a_of(2, 3), 32'h0000_FFFF);
    bus(1'b1, 10'h040, '1, 4'hF, q);
    rdc(10'h040, 32'h0);
    rdc(10'h300, 32'h0);
    rdc(a_of(0, 0), 32'h0);
    bus(1'b1, a_of(1, 3), '1, 4'hF, q);
    bus(1'b1, a_of(3, 3), '1, 4'hF, q);
    // Pulse on disabled 70, held level on 200
    lines[70] <= 1'b1;
    @(posedge clk_i);
    lines[70]   <= 1'b0;
    lsense[200] <= 1'b1;
    lines[200]  <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc(a_of(2, 2), 32'h0000_0040);
    rdc(a_of(2, 6), 32'h0000_0100);
    cmp_word(32'(take.valid), 32'h0);
    bus(1'b1, a_of(0, 2), 32'h0000_0040, 4'hF, q);
    bus(1'b1, a_of(0, 6), 32'h0000_0100, 4'hF, q);
    cmp_id(take.id, 200);
    accept <= 1'b1;
    @(posedge clk_i);
    while (act.strobe !== 1'b1)
      @(posedge clk_i);
    accept <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp_id(take.id, 70);
    rdc(a_of(4, 6), 32'h0000_0100);
    rdc(a_of(2, 6), 32'h0);
    bus(1'b1, a_of(3, 6), '1, 4'hF, q);
    rdc(a_of(4, 6), 32'h0000_0100);
    while (ret.strobe !== 1'b1)
      @(posedge clk_i);
    rdc(a_of(2, 6), 32'h0000_0100);
    rdc(a_of(4, 6), 32'h0);
    conclude();
  end
endmodule : test_irq_enable_pending_active_bank
`default_nettype wire
